/* File: pms_core.sv */
// Power-good masking with assert/release delays and sync pin role selection.
// Assumes i_clk_sys is the switching clock and all inputs are synchronous to it.

module pms_core (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_cmd,
   input wire logic [15:0] i_wr_data,
   input wire pms_pkg::pms_event_t i_event,
   input wire logic i_enable_cond,
   input wire logic i_sync_in,
   input wire logic [15:0] i_pwm_period,
   output logic [15:0] o_power_ok_mask_delay,
   output logic [7:0] o_clock_alignment_setup,
   output logic o_power_ok_output,
   output logic o_sync_out,
   output logic o_sync_oe,
   output logic o_pwm_start,
   output pms_pkg::pms_role_t o_sync_role
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [15:0] pg_cfg_reg;
   logic [7:0] sync_cfg_reg;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pg_cfg_reg <= pms_pkg::POWER_OK_MASK_DELAY_RST;
      end else if (i_wr_en && i_wr_cmd == pms_pkg::CMD_POWER_OK_MASK_DELAY) begin
         pg_cfg_reg <= i_wr_data;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sync_cfg_reg <= pms_pkg::CLOCK_ALIGNMENT_SETUP_RST;
      end else if (i_wr_en && i_wr_cmd == pms_pkg::CMD_CLOCK_ALIGNMENT_SETUP) begin
         sync_cfg_reg <= i_wr_data[7:0];
      end
   end

   assign o_power_ok_mask_delay = pg_cfg_reg;
   assign o_clock_alignment_setup = sync_cfg_reg;

   // ----------------------------------------------------------------
   // Event masking
   // ----------------------------------------------------------------
   logic [7:0] mask;
   logic [7:0] ev_bits;
   logic [7:0] ev_live;
   logic unmasked_any;

   assign mask = pg_cfg_reg[pms_pkg::MASK_MSB:pms_pkg::MASK_LSB];
   assign ev_bits = i_event;

   // Struct order puts each event on its mask bit
   for (genvar b = 0; b < 8; b++) begin : g_mask
      assign ev_live[b] = ev_bits[b] && (mask[b] == pms_pkg::MASK_LETS_EVENT);
   end

   assign unmasked_any = (|ev_live[7:6])
      || (|ev_live[5:4])
      || (|ev_live[3:2])
      || (|ev_live[1:0]);

   // ----------------------------------------------------------------
   // Power-good delays
   // ----------------------------------------------------------------
   function automatic logic [15:0] dly_cycles(input logic [3:0] code);
      logic [15:0] one;
      one = 16'h0001;
      if (code == pms_pkg::DLY_CODE_MIN) begin
         dly_cycles = pms_pkg::DLY_ONE_CYCLE;
      end else begin
         dly_cycles = (one << code) + one;
      end
   endfunction

   logic [15:0] off_cycles;
   logic [15:0] on_cycles;
   logic [15:0] pg_cnt_reg;
   pms_pkg::pms_pg_state_t pg_state_reg;

   assign off_cycles = dly_cycles(pg_cfg_reg[pms_pkg::OFF_DLY_MSB:pms_pkg::OFF_DLY_LSB]);
   assign on_cycles = dly_cycles(pg_cfg_reg[pms_pkg::ON_DLY_MSB:pms_pkg::ON_DLY_LSB]);

   // Counter restarts whenever the condition flips, so glitches shorter
   // than the delay never reach the pin.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pg_state_reg <= pms_pkg::PG_HIGH;
         pg_cnt_reg <= 16'h0000;
         o_power_ok_output <= 1'b1;
      end else begin
         unique case (pg_state_reg)
            pms_pkg::PG_HIGH: begin
               pg_cnt_reg <= 16'h0001;
               if (unmasked_any) begin
                  if (off_cycles == pms_pkg::DLY_ONE_CYCLE) begin
                     pg_state_reg <= pms_pkg::PG_LOW;
                     o_power_ok_output <= 1'b0;
                  end else begin
                     pg_state_reg <= pms_pkg::PG_FALLING;
                  end
               end
            end
            pms_pkg::PG_FALLING: begin
               if (!unmasked_any) begin
                  pg_state_reg <= pms_pkg::PG_HIGH;
               end else if (pg_cnt_reg + 16'h0001 >= off_cycles) begin
                  pg_state_reg <= pms_pkg::PG_LOW;
                  o_power_ok_output <= 1'b0;
               end else begin
                  pg_cnt_reg <= pg_cnt_reg + 16'h0001;
               end
            end
            pms_pkg::PG_LOW: begin
               pg_cnt_reg <= 16'h0001;
               if (!unmasked_any) begin
                  if (on_cycles == pms_pkg::DLY_ONE_CYCLE) begin
                     pg_state_reg <= pms_pkg::PG_HIGH;
                     o_power_ok_output <= 1'b1;
                  end else begin
                     pg_state_reg <= pms_pkg::PG_RISING;
                  end
               end
            end
            pms_pkg::PG_RISING: begin
               if (unmasked_any) begin
                  pg_state_reg <= pms_pkg::PG_LOW;
               end else if (pg_cnt_reg + 16'h0001 >= on_cycles) begin
                  pg_state_reg <= pms_pkg::PG_HIGH;
                  o_power_ok_output <= 1'b1;
               end else begin
                  pg_cnt_reg <= pg_cnt_reg + 16'h0001;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Sync role selection
   // ----------------------------------------------------------------
   logic [1:0] sync_dir;
   logic enable_d_reg;
   logic auto_role_in_reg;

   assign sync_dir = sync_cfg_reg[pms_pkg::SYNC_DIR_MSB:pms_pkg::SYNC_DIR_LSB];

   // High pin at enable means another module already drives it
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         enable_d_reg <= 1'b0;
         auto_role_in_reg <= 1'b0;
      end else begin
         enable_d_reg <= i_enable_cond;
         if (i_enable_cond && !enable_d_reg) begin
            auto_role_in_reg <= i_sync_in;
         end
      end
   end

   pms_pkg::pms_role_t role_next;

   always_comb begin
      unique case (sync_dir)
         pms_pkg::SYNC_DIR_OFF: role_next = pms_pkg::ROLE_NONE;
         pms_pkg::SYNC_DIR_OUT: role_next = pms_pkg::ROLE_SOURCE;
         pms_pkg::SYNC_DIR_IN: role_next = pms_pkg::ROLE_FOLLOW;
         pms_pkg::SYNC_DIR_AUTO: role_next = auto_role_in_reg ? pms_pkg::ROLE_FOLLOW
                                                            : pms_pkg::ROLE_SOURCE;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_sync_role <= pms_pkg::ROLE_NONE;
      end else begin
         o_sync_role <= role_next;
      end
   end

   // ----------------------------------------------------------------
   // Switching timebase and pin drive
   // ----------------------------------------------------------------
   logic sync_d_reg;
   logic ref_edge;
   logic [15:0] per_cnt_reg;
   logic per_wrap;
   pms_pkg::pms_pin_t pin_next;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sync_d_reg <= 1'b0;
      end else begin
         sync_d_reg <= i_sync_in;
      end
   end

   assign ref_edge = (sync_cfg_reg[pms_pkg::SYNC_EDGE_BIT] == pms_pkg::SYNC_EDGE_FALL)
      ? (sync_d_reg && !i_sync_in) : (!sync_d_reg && i_sync_in);
   assign per_wrap = (per_cnt_reg + 16'h0001 >= i_pwm_period);

   // Following a reference: its edge restarts the period, the free run
   // covers a missing reference or one slower than i_pwm_period.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         per_cnt_reg <= 16'h0000;
         o_pwm_start <= 1'b0;
      end else if (o_sync_role == pms_pkg::ROLE_FOLLOW && ref_edge) begin
         per_cnt_reg <= 16'h0000;
         o_pwm_start <= 1'b1;
      end else if (per_wrap) begin
         per_cnt_reg <= 16'h0000;
         o_pwm_start <= 1'b1;
      end else begin
         per_cnt_reg <= per_cnt_reg + 16'h0001;
         o_pwm_start <= 1'b0;
      end
   end

   always_comb begin
      pin_next.oe = (o_sync_role == pms_pkg::ROLE_SOURCE);
      pin_next.drive = pin_next.oe && (per_cnt_reg < (i_pwm_period >> 1));
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_sync_oe <= 1'b0;
         o_sync_out <= 1'b0;
      end else begin
         o_sync_oe <= pin_next.oe;
         o_sync_out <= pin_next.drive;
      end
   end

endmodule // pms_core

/* File: pms_pkg.sv */
// Package for the power-good mask and synchronization select block.
// Assumes a single switching-clock domain; used by pms_core only through pms_pkg::name.
package pms_pkg;

   // ----------------------------------------------------------------
   // Register command codes and widths
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_POWER_OK_MASK_DELAY = 8'hE3;
   localparam logic [7:0] CMD_CLOCK_ALIGNMENT_SETUP = 8'hE4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned DLY_W = 16;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned OFF_DLY_MSB = 15;
   localparam int unsigned OFF_DLY_LSB = 12;
   localparam int unsigned ON_DLY_MSB = 11;
   localparam int unsigned ON_DLY_LSB = 8;
   localparam int unsigned MASK_MSB = 7;
   localparam int unsigned MASK_LSB = 0;
   localparam int unsigned SYNC_DIR_MSB = 7;
   localparam int unsigned SYNC_DIR_LSB = 6;
   localparam int unsigned SYNC_EDGE_BIT = 5;

   // ----------------------------------------------------------------
   // Reset values and codes
   // ----------------------------------------------------------------
   localparam logic [15:0] POWER_OK_MASK_DELAY_RST = 16'h0000;
   localparam logic [7:0] CLOCK_ALIGNMENT_SETUP_RST = 8'h00;
   localparam logic [1:0] SYNC_DIR_OFF = 2'h0;
   localparam logic [1:0] SYNC_DIR_OUT = 2'h1;
   localparam logic [1:0] SYNC_DIR_IN = 2'h2;
   localparam logic [1:0] SYNC_DIR_AUTO = 2'h3;
   localparam logic SYNC_EDGE_FALL = 1'b0;
   localparam logic MASK_LETS_EVENT = 1'b0;
   localparam logic [3:0] DLY_CODE_MIN = 4'h0;
   localparam logic [15:0] DLY_ONE_CYCLE = 16'h0001;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam logic [15:0] PWM_PERIOD_RST = 16'h0064;

   // Fault and warning inputs in mask-bit order, bit 7 first
   typedef struct packed {
      logic vout_ov_fault;
      logic vout_ov_warn;
      logic vout_uv_fault;
      logic vout_uv_warn;
      logic iout_oc_warn;
      logic iout_oc_fault;
      logic vin_ov_warn;
      logic vin_ov_fault;
   } pms_event_t;

   // Sync pin drive as one carrier
   typedef struct packed {
      logic drive;
      logic oe;
   } pms_pin_t;

   typedef enum logic [1:0] {
      ROLE_NONE,
      ROLE_SOURCE,
      ROLE_FOLLOW
   } pms_role_t;

   typedef enum logic [1:0] {
      PG_HIGH,
      PG_FALLING,
      PG_LOW,
      PG_RISING
   } pms_pg_state_t;

endpackage

/* File: pms_monitor.sv */
// Port checker for pms_core, bound into every instance.
// Assumes one switching clock and readback ports that mirror the registers.
module pms_monitor (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_cmd,
   input wire logic [15:0] i_wr_data,
   input wire pms_pkg::pms_event_t i_event,
   input wire logic i_enable_cond,
   input wire logic i_sync_in,
   input wire logic [15:0] i_pwm_period,
   input wire logic [15:0] o_power_ok_mask_delay,
   input wire logic [7:0] o_clock_alignment_setup,
   input wire logic o_power_ok_output,
   input wire logic o_sync_out,
   input wire logic o_sync_oe,
   input wire logic o_pwm_start,
   input wire pms_pkg::pms_role_t o_sync_role
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   logic [7:0] unm;
   logic [1:0] dir;
   logic pg;
   assign unm = i_event & ~o_power_ok_mask_delay[7:0];
   assign dir = o_clock_alignment_setup[7:6];
   assign pg = o_power_ok_output;
   wr_readback_a: assert property (i_wr_en && i_wr_cmd == 8'hE3 |=>
      o_power_ok_mask_delay == $past(i_wr_data)) else $error("mask readback wrong");
   role_fixed_a: assert property (dir != 2'h3 |=>
      o_sync_role == pms_pkg::pms_role_t'($past(dir))) else $error("role wrong");
   oe_role_a: assert property (1'b1 |=>
      o_sync_oe == ($past(o_sync_role) == pms_pkg::ROLE_SOURCE)) else $error("oe wrong");
   follow_edge_a: assert property (o_sync_role == pms_pkg::ROLE_FOLLOW &&
      (o_clock_alignment_setup[5] ? $rose(i_sync_in) : $fell(i_sync_in)) |=> o_pwm_start)
      else $error("no start on pin edge");
   auto_pick_a: assert property (dir == 2'h3 && $rose(i_enable_cond) ##1 dir == 2'h3 |=>
      o_sync_role == ($past(i_sync_in, 2) ? pms_pkg::ROLE_FOLLOW : pms_pkg::ROLE_SOURCE))
      else $error("auto role wrong");
   masked_hold_a: assert property ($past(pg) && unm == 8'h00 &&
      $past(unm) == 8'h00 |-> pg) else $error("masked event lowered power ok");
   off_delay_a: assert property (pg && unm != 8'h00 &&
      o_power_ok_mask_delay[15:12] == 4'h1 ##1 unm != 8'h00 [*2] |=> !pg)
      else $error("off delay wrong");
   on_delay_a: assert property (!pg && unm == 8'h00 &&
      o_power_ok_mask_delay[11:8] == 4'h0 |=> pg) else $error("on delay wrong");
   cover property (o_pwm_start && o_sync_role == pms_pkg::ROLE_FOLLOW);
   cover property ($fell(pg));
   cover property (o_sync_oe && dir == 2'h3);
endmodule // pms_monitor

bind pms_core pms_monitor mon_u (.i_clk_sys, .i_rst, .i_wr_en, .i_wr_cmd, .i_wr_data,
   .i_event, .i_enable_cond, .i_sync_in, .i_pwm_period, .o_power_ok_mask_delay,
   .o_clock_alignment_setup, .o_power_ok_output, .o_sync_out, .o_sync_oe,
   .o_pwm_start, .o_sync_role);

/* File: pms_sync_peer.sv */
// Neighbour regulator on the shared sync line: release, hold a level, or clock.
// Assumes the bench resolves the pin from every party's enable.
module pms_sync_peer #(
   parameter int HALF = 7
) (
   input wire logic i_clk_sys,
   input wire logic [1:0] i_mode,
   output logic o_drive,
   output logic o_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   always_ff @(posedge i_clk_sys) begin
      cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
      o_oe <= i_mode != 2'h0;
      o_drive <= (i_mode == 2'h3) ? (cnt < HALF) : i_mode[1];
   end
endmodule // pms_sync_peer

/* File: test_power_good_mask_and_sync_select.sv */
// Self-checking bench for pms_core with a sync-line neighbour model.
// Assumes pms_monitor is bound in and internal period is fixed at sixteen clocks.
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_power_good_mask_and_sync_select;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, en_c = 1'b0, flt = 1'b0, src;
   logic [7:0] cmd = 8'h00, ev = 8'h00, m, e, rb_cs;
   logic [7:0] cs_t [4] = '{8'h00, 8'h40, 8'h80, 8'hA0};
   logic [15:0] wdat = 16'h0000, rb_md;
   logic pg, s_out, s_oe, pst, p_out, p_oe, pin;
   logic [1:0] p_mode = 2'h0;
   pms_pkg::pms_role_t role;
   int seed = 22, failures = 0, checks_done = 0, np, nh;
   initial forever #5 clk = ~clk;
   // Undriven line shows a changing level, never the last one
   always @(posedge clk) flt <= ~flt;
   assign pin = s_oe ? s_out : (p_oe ? p_out : flt);
   pms_core dut_u (.i_clk_sys(clk), .i_rst(rst), .i_wr_en(wr_en), .i_wr_cmd(cmd),
      .i_wr_data(wdat), .i_event(pms_pkg::pms_event_t'(ev)), .i_enable_cond(en_c),
      .i_sync_in(pin), .i_pwm_period(16'h0010), .o_power_ok_mask_delay(rb_md),
      .o_clock_alignment_setup(rb_cs), .o_power_ok_output(pg), .o_sync_out(s_out),
      .o_sync_oe(s_oe), .o_pwm_start(pst), .o_sync_role(role));
   pms_sync_peer #(.HALF(7)) peer_u (.i_clk_sys(clk), .i_mode(p_mode), .o_drive(p_out),
      .o_oe(p_oe));
   function automatic int dly(input int c);
      return (c == 0) ? 1 : (1 << c) + 1;
   endfunction
   task automatic finish_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      cmd <= c;
      wdat <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic meas(input logic lvl, input int exp_n);
      int n;
      n = 0;
      #1;
      while (pg !== lvl && n < 100) begin
         cyc(1);
         n++;
      end
      `CHK(n, exp_n)
      if (n >= 100) finish_test();
   endtask
   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      cyc(1);
      `CHK(rb_md, 16'h0000)
      `CHK(pg, 1'b1)
      `CHK(s_oe, 1'b0)
      for (int k = 0; k < 32; k++) begin
         e = (k < 16) ? (8'h01 << k[2:0]) : 8'($random(seed));
         m = (k < 8) ? ~e : ((k < 16) ? e : 8'($random(seed)));
         wr(8'hE3, {8'h00, m});
         @(posedge clk);
         ev <= e;
         cyc(3);
         `CHK(pg, (e & ~m) == 8'h00)
         @(posedge clk);
         ev <= 8'h00;
         cyc(3);
         `CHK(pg, 1'b1)
      end
      for (int c = 0; c < 4; c++) begin
         wr(8'hE3, {c[3:0], c[3:0], 8'h00});
         @(posedge clk);
         ev <= 8'h80;
         meas(1'b0, dly(c));
         @(posedge clk);
         ev <= 8'h00;
         meas(1'b1, dly(c));
      end
      // Event shorter than the nine-cycle off delay must not show
      @(posedge clk);
      ev <= 8'h01;
      repeat (4) @(posedge clk);
      ev <= 8'h00;
      cyc(12);
      `CHK(pg, 1'b1)
      wr(8'hE5, 16'($random(seed)));
      cyc(1);
      `CHK(rb_md, 16'h3300)
      for (int i = 0; i < 4; i++) begin
         src = cs_t[i][7:6] == 2'h1;
         @(posedge clk);
         if (src) p_mode <= 2'h0;
         wr(8'hE4, {8'h00, cs_t[i]});
         cyc(4);
         `CHK(role, pms_pkg::pms_role_t'(cs_t[i][7:6]))
         `CHK(s_oe, src)
         `CHK(rb_cs, cs_t[i])
         @(posedge clk);
         if (!src) p_mode <= 2'h3;
         // Settle past the first neighbour edge; its period of 14 stays
         // below the internal 16, so every start in follow comes from the pin.
         cyc(20);
         np = 0;
         nh = 0;
         repeat (112) begin
            cyc(1);
            np += (pst === 1'b1);
            nh += (s_out === 1'b1);
            if (pst === 1'b1 && cs_t[i][7:6] == 2'h2) `CHK(pin, cs_t[i][5])
         end
         `CHK(np, (cs_t[i][7:6] == 2'h2) ? 8 : 7)
         if (src) `CHK(nh, 56)
      end
      @(posedge clk);
      p_mode <= 2'h2;
      wr(8'hE4, 16'h00C0);
      @(posedge clk);
      en_c <= 1'b1;
      cyc(4);
      `CHK(role, pms_pkg::ROLE_FOLLOW)
      @(posedge clk);
      en_c <= 1'b0;
      p_mode <= 2'h1;
      @(posedge clk);
      en_c <= 1'b1;
      @(posedge clk);
      p_mode <= 2'h0;
      cyc(4);
      `CHK(role, pms_pkg::ROLE_SOURCE)
      `CHK(s_oe, 1'b1)
      finish_test();
   end
endmodule // test_power_good_mask_and_sync_select
